// ---- verilog/mprs_device.sv ----
// Module end of the power-on, shutdown and reset sequencer.
`include "mprs_consts.svh"

module mprs_device #(
  parameter int unsigned T_ON_MIN_CYC    = `MPRS_T_ON_MIN_CYC,
  parameter int unsigned T_RST_MIN_CYC   = `MPRS_T_RST_MIN_CYC,
  parameter int unsigned T_HWOFF_MIN_CYC = `MPRS_T_HWOFF_MIN_CYC
) (
  // Clock and reset.
  input  wire logic clk,
  input  wire logic rst_n,
  // Pins from the host.
  mprs_if.dev       pins,
  // Finalization handshake with the module firmware.
  input  wire logic saveDone,
  input  wire logic clearDone,
  // Status towards the module.
  output logic      bootStart,
  output logic      moduleReady,
  output logic      saveStart,
  output logic      clearStart,
  output logic      pmuPowered,
  output logic      usbHighSpeed,
  output logic      usbFullSpeed
);

  // ****************************************************************
  // Parameter checks
  // ****************************************************************

  // A zero threshold would let a one-cycle glitch count as a pulse.
  if (T_ON_MIN_CYC < 1 || T_RST_MIN_CYC < 1 || T_HWOFF_MIN_CYC < 1) begin : gChk
    $error("mprs_device: every threshold must be at least one cycle.");
  end

  // ****************************************************************
  // Level duration counters
  // ****************************************************************

  localparam int NLVL = 3;
  localparam int LVL_HIGH = 0;
  localparam int LVL_LOW  = 1;
  localparam int LVL_RST  = 2;

  logic             lvlIn [NLVL];
  mprs_pkg::mprs_cnt_t lvlCnt_r [NLVL];

  // Each counter counts consecutive cycles of its level and saturates.
  assign lvlIn[LVL_HIGH] = pins.powerCtl;
  assign lvlIn[LVL_LOW]  = ~pins.powerCtl;
  assign lvlIn[LVL_RST]  = ~pins.resetN;

  // Saturating increment so that a long level never wraps to a short one.
  function automatic mprs_pkg::mprs_cnt_t satInc(input mprs_pkg::mprs_cnt_t v);
    satInc = (v == 32'hFFFF_FFFF) ? v : v + 32'h0000_0001;
  endfunction : satInc

  // One counter per watched level.
  for (genvar i = 0; i < NLVL; i++) begin : gLvl
    always_ff @(posedge clk) begin
      if (!rst_n) begin
        lvlCnt_r[i] <= 32'h0000_0000;
      end else if (lvlIn[i]) begin
        lvlCnt_r[i] <= satInc(lvlCnt_r[i]);
      end else begin
        lvlCnt_r[i] <= 32'h0000_0000;
      end
    end
  end

  // ****************************************************************
  // Threshold decode
  // ****************************************************************

  // Strictly longer than the minimum, as each time is a lower bound.
  wire logic onLong;
  wire logic offLong;
  wire logic rstLong;

  assign onLong  = pins.powerCtl && (lvlCnt_r[LVL_HIGH] >= T_ON_MIN_CYC);
  assign offLong = !pins.powerCtl && (lvlCnt_r[LVL_LOW] >= T_HWOFF_MIN_CYC);
  // At the release cycle the counter still holds the length of the pulse.
  assign rstLong = pins.resetN && (lvlCnt_r[LVL_RST] > T_RST_MIN_CYC);

  // ****************************************************************
  // Sequencer state machine
  // ****************************************************************

  mprs_pkg::mprs_dev_state_e state_r;
  mprs_pkg::mprs_dev_state_e state_nxt;
  logic bootStart_r;
  logic bootStart_nxt;
  logic saveStart_r;
  logic saveStart_nxt;
  logic clearStart_r;
  logic clearStart_nxt;
  logic offOk_r;
  logic offOk_nxt;
  logic pmuPowered_r;
  logic pmuPowered_nxt;
  logic moduleReady_r;
  logic moduleReady_nxt;
  logic usbHs_r;
  logic usbFs_r;

  // Next state, pulses and power levels.
  always_comb begin
    state_nxt       = state_r;
    bootStart_nxt   = 1'b0;
    saveStart_nxt   = 1'b0;
    clearStart_nxt  = 1'b0;
    offOk_nxt       = 1'b0;
    pmuPowered_nxt  = pmuPowered_r;
    moduleReady_nxt = moduleReady_r;
    unique case (state_r)
      mprs_pkg::DEV_OFF: begin
        pmuPowered_nxt  = 1'b0;
        moduleReady_nxt = 1'b0;
        if (onLong) begin
          state_nxt       = mprs_pkg::DEV_RUN;
          bootStart_nxt   = 1'b1;
          pmuPowered_nxt  = 1'b1;
          moduleReady_nxt = 1'b1;
        end
      end
      mprs_pkg::DEV_RUN: begin
        if (offLong) begin
          state_nxt       = mprs_pkg::DEV_OFF;
          pmuPowered_nxt  = 1'b0;
          moduleReady_nxt = 1'b0;
        end else if (!pins.resetN) begin
          state_nxt       = mprs_pkg::DEV_RST;
          moduleReady_nxt = 1'b0;
        end else if (pins.offCmd) begin
          state_nxt       = mprs_pkg::DEV_SAVE;
          saveStart_nxt   = 1'b1;
          moduleReady_nxt = 1'b0;
        end
      end
      mprs_pkg::DEV_RST: begin
        // The power unit is held on throughout the reset.
        pmuPowered_nxt = 1'b1;
        if (offLong) begin
          // A forced off during the reset, as the host is told to do it.
          state_nxt      = mprs_pkg::DEV_OFF;
          pmuPowered_nxt = 1'b0;
        end else if (rstLong) begin
          state_nxt       = mprs_pkg::DEV_RUN;
          bootStart_nxt   = 1'b1;
          moduleReady_nxt = 1'b1;
        end else if (pins.resetN) begin
          // A pulse too short to count is ignored and the module resumes.
          state_nxt       = mprs_pkg::DEV_RUN;
          moduleReady_nxt = 1'b1;
        end
      end
      mprs_pkg::DEV_SAVE: begin
        if (offLong) begin
          state_nxt      = mprs_pkg::DEV_OFF;
          pmuPowered_nxt = 1'b0;
        end else if (saveDone) begin
          state_nxt      = mprs_pkg::DEV_CLEAR;
          clearStart_nxt = 1'b1;
        end
      end
      mprs_pkg::DEV_CLEAR: begin
        if (offLong) begin
          state_nxt      = mprs_pkg::DEV_OFF;
          pmuPowered_nxt = 1'b0;
        end else if (clearDone) begin
          state_nxt      = mprs_pkg::DEV_SWOFF;
          pmuPowered_nxt = 1'b0;
          offOk_nxt      = 1'b1;
        end
      end
      mprs_pkg::DEV_SWOFF: begin
        // The control is still high on entry; only a low level rearms start-up.
        pmuPowered_nxt = 1'b0;
        if (!pins.powerCtl) begin
          state_nxt = mprs_pkg::DEV_OFF;
        end
      end
      default: begin
        state_nxt       = mprs_pkg::DEV_OFF;
        pmuPowered_nxt  = 1'b0;
        moduleReady_nxt = 1'b0;
      end
    endcase
  end

  // State and output registers.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_r       <= mprs_pkg::DEV_OFF;
      bootStart_r   <= 1'b0;
      saveStart_r   <= 1'b0;
      clearStart_r  <= 1'b0;
      offOk_r       <= 1'b0;
      pmuPowered_r  <= 1'b0;
      moduleReady_r <= 1'b0;
    end else begin
      state_r       <= state_nxt;
      bootStart_r   <= bootStart_nxt;
      saveStart_r   <= saveStart_nxt;
      clearStart_r  <= clearStart_nxt;
      offOk_r       <= offOk_nxt;
      pmuPowered_r  <= pmuPowered_nxt;
      moduleReady_r <= moduleReady_nxt;
    end
  end

  // ****************************************************************
  // Host data port capabilities
  // ****************************************************************

  // Both signalling rates are advertised once reset is released.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      usbHs_r <= 1'b0;
      usbFs_r <= 1'b0;
    end else begin
      usbHs_r <= 1'b1;
      usbFs_r <= 1'b1;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************

  assign pins.offOk   = offOk_r;
  assign bootStart    = bootStart_r;
  assign moduleReady  = moduleReady_r;
  assign saveStart    = saveStart_r;
  assign clearStart   = clearStart_r;
  assign pmuPowered   = pmuPowered_r;
  assign usbHighSpeed = usbHs_r;
  assign usbFullSpeed = usbFs_r;

endmodule : mprs_device

// ---- verilog/mprs_consts.svh ----
// Timing and reset constants shared by both ends of the power and reset sequencer.
`ifndef MPRS_CONSTS_SVH
`define MPRS_CONSTS_SVH

// ****************************************************************
// Clock rate
// ****************************************************************
`define MPRS_CLK_MHZ          250
`define MPRS_CYC_PER_MS       (`MPRS_CLK_MHZ * 1000)

// ****************************************************************
// Times in milliseconds
// ****************************************************************
`define MPRS_T_ON_MIN_MS      20
`define MPRS_T_ON_REC_MS      100
`define MPRS_T_RST_MIN_MS     10
`define MPRS_T_RST_REC_MS     100
`define MPRS_T_HWOFF_MIN_MS   50
`define MPRS_T_HWOFF_REC_MS   100
`define MPRS_T_HWRST_PRE_MS   100
`define MPRS_T_SD_MAX_MS      5000

// ****************************************************************
// Cycle counts derived from the times
// ****************************************************************
`define MPRS_T_ON_MIN_CYC     (`MPRS_T_ON_MIN_MS * `MPRS_CYC_PER_MS)
`define MPRS_T_ON_REC_CYC     (`MPRS_T_ON_REC_MS * `MPRS_CYC_PER_MS)
`define MPRS_T_RST_MIN_CYC    (`MPRS_T_RST_MIN_MS * `MPRS_CYC_PER_MS)
`define MPRS_T_RST_REC_CYC    (`MPRS_T_RST_REC_MS * `MPRS_CYC_PER_MS)
`define MPRS_T_HWOFF_MIN_CYC  (`MPRS_T_HWOFF_MIN_MS * `MPRS_CYC_PER_MS)
`define MPRS_T_HWOFF_REC_CYC  (`MPRS_T_HWOFF_REC_MS * `MPRS_CYC_PER_MS)
`define MPRS_T_HWRST_PRE_CYC  (`MPRS_T_HWRST_PRE_MS * `MPRS_CYC_PER_MS)
`define MPRS_T_SD_MAX_CYC     (`MPRS_T_SD_MAX_MS * `MPRS_CYC_PER_MS)

// ****************************************************************
// Counter width and pin reset levels
// ****************************************************************
`define MPRS_CNT_W            32
`define MPRS_PWR_RST_LVL      1'b0
`define MPRS_RSTN_RST_LVL     1'b1

`endif

// ---- verilog/mprs_pkg.sv ----
// State types of the device and host ends of the power and reset sequencer.
package mprs_pkg;

  // ****************************************************************
  // Device end states
  // ****************************************************************
  typedef enum logic [2:0] {
    DEV_OFF   = 3'b000,
    DEV_RUN   = 3'b001,
    DEV_RST   = 3'b010,
    DEV_SAVE  = 3'b011,
    DEV_CLEAR = 3'b100,
    DEV_SWOFF = 3'b101
  } mprs_dev_state_e;

  // ****************************************************************
  // Host end states
  // ****************************************************************
  typedef enum logic [2:0] {
    HST_IDLE  = 3'b000,
    HST_START = 3'b001,
    HST_RESET = 3'b010,
    HST_SWCMD = 3'b011,
    HST_SWLOW = 3'b100,
    HST_HWRST = 3'b101,
    HST_HWLOW = 3'b110
  } mprs_hst_state_e;

  typedef logic [31:0] mprs_cnt_t;

endpackage : mprs_pkg

// ---- verilog/mprs_if.sv ----
// Pins between the host application processor and the modem module.
interface mprs_if;

  logic powerCtl;
  logic resetN;
  logic offCmd;
  logic offOk;

  // Device end receives the pins and answers the power-down command.
  modport dev (
    input  powerCtl,
    input  resetN,
    input  offCmd,
    output offOk
  );

  // Host end drives the pins and waits for the answer.
  modport host (
    output powerCtl,
    output resetN,
    output offCmd,
    input  offOk
  );

endinterface : mprs_if

// ---- verilog/mprs_host.sv ----
// Host end of the power-on, shutdown and reset sequencer.
`include "mprs_consts.svh"

module mprs_host #(
  parameter int unsigned T_ON_HOLD_CYC    = `MPRS_T_ON_REC_CYC,
  parameter int unsigned T_RST_HOLD_CYC   = `MPRS_T_RST_REC_CYC,
  parameter int unsigned T_HWOFF_HOLD_CYC = `MPRS_T_HWOFF_REC_CYC,
  parameter int unsigned T_HWRST_PRE_CYC  = `MPRS_T_HWRST_PRE_CYC,
  parameter int unsigned T_SD_MAX_CYC     = `MPRS_T_SD_MAX_CYC
) (
  // Clock and reset.
  input  wire logic clk,
  input  wire logic rst_n,
  // Pins towards the module.
  mprs_if.host      pins,
  // Sequence requests from the application.
  input  wire logic startReq,
  input  wire logic resetReq,
  input  wire logic swOffReq,
  input  wire logic hwOffReq,
  // Sequence status.
  output logic      busy,
  output logic      done,
  output logic      timedOut
);

  // ****************************************************************
  // Parameter checks
  // ****************************************************************

  // Every hold and the timeout must last at least one cycle; a zero value would end each hold on its first cycle.
  if (T_ON_HOLD_CYC < 1 || T_RST_HOLD_CYC < 1 ||
      T_HWOFF_HOLD_CYC < 1 || T_HWRST_PRE_CYC < 1 || T_SD_MAX_CYC < 1) begin : gChk
    $error("mprs_host: hold times out of range.");
  end

  // ****************************************************************
  // Sequencer state machine
  // ****************************************************************

  mprs_pkg::mprs_hst_state_e state_r;
  mprs_pkg::mprs_hst_state_e state_nxt;
  mprs_pkg::mprs_cnt_t       cnt_r;
  mprs_pkg::mprs_cnt_t       cnt_nxt;
  logic powerCtl_r;
  logic powerCtl_nxt;
  logic resetN_r;
  logic resetN_nxt;
  logic offCmd_r;
  logic offCmd_nxt;
  logic done_r;
  logic done_nxt;
  logic timedOut_r;
  logic timedOut_nxt;

  wire logic cntEnd;

  // Terminal count of the hold that the present state runs.
  assign cntEnd = (state_r == mprs_pkg::HST_START) ? (cnt_r >= T_ON_HOLD_CYC) :
                  (state_r == mprs_pkg::HST_RESET) ? (cnt_r >= T_RST_HOLD_CYC) :
                  (state_r == mprs_pkg::HST_SWCMD) ? (cnt_r >= T_SD_MAX_CYC) :
                  (state_r == mprs_pkg::HST_HWRST) ? (cnt_r >= T_HWRST_PRE_CYC) :
                  (cnt_r >= T_HWOFF_HOLD_CYC);

  // Next state; requests are taken only when idle, one at a time.
  always_comb begin
    state_nxt    = state_r;
    cnt_nxt      = cnt_r + 32'h0000_0001;
    powerCtl_nxt = powerCtl_r;
    resetN_nxt   = resetN_r;
    offCmd_nxt   = 1'b0;
    done_nxt     = 1'b0;
    timedOut_nxt = timedOut_r;
    unique case (state_r)
      mprs_pkg::HST_IDLE: begin
        cnt_nxt = 32'h0000_0001;
        if (startReq) begin
          state_nxt    = mprs_pkg::HST_START;
          powerCtl_nxt = 1'b1;
        end else if (resetReq) begin
          state_nxt  = mprs_pkg::HST_RESET;
          resetN_nxt = 1'b0;
        end else if (swOffReq) begin
          state_nxt    = mprs_pkg::HST_SWCMD;
          offCmd_nxt   = 1'b1;
          timedOut_nxt = 1'b0;
        end else if (hwOffReq) begin
          state_nxt  = mprs_pkg::HST_HWRST;
          resetN_nxt = 1'b0;
        end
      end
      mprs_pkg::HST_START: begin
        if (cntEnd) begin
          state_nxt = mprs_pkg::HST_IDLE;
          done_nxt  = 1'b1;
        end
      end
      mprs_pkg::HST_RESET: begin
        if (cntEnd) begin
          state_nxt  = mprs_pkg::HST_IDLE;
          resetN_nxt = 1'b1;
          done_nxt   = 1'b1;
        end
      end
      mprs_pkg::HST_SWCMD: begin
        if (pins.offOk || cntEnd) begin
          state_nxt    = mprs_pkg::HST_SWLOW;
          timedOut_nxt = !pins.offOk;
          powerCtl_nxt = 1'b0;
          cnt_nxt      = 32'h0000_0001;
        end
      end
      mprs_pkg::HST_HWRST: begin
        if (cntEnd) begin
          state_nxt    = mprs_pkg::HST_HWLOW;
          powerCtl_nxt = 1'b0;
          cnt_nxt      = 32'h0000_0001;
        end
      end
      mprs_pkg::HST_SWLOW,
      mprs_pkg::HST_HWLOW: begin
        if (cntEnd) begin
          state_nxt  = mprs_pkg::HST_IDLE;
          resetN_nxt = 1'b1;
          done_nxt   = 1'b1;
        end
      end
      default: begin
        state_nxt = mprs_pkg::HST_IDLE;
      end
    endcase
  end

  // State and pin registers.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_r    <= mprs_pkg::HST_IDLE;
      cnt_r      <= 32'h0000_0000;
      powerCtl_r <= `MPRS_PWR_RST_LVL;
      resetN_r   <= `MPRS_RSTN_RST_LVL;
      offCmd_r   <= 1'b0;
      done_r     <= 1'b0;
      timedOut_r <= 1'b0;
    end else begin
      state_r    <= state_nxt;
      cnt_r      <= cnt_nxt;
      powerCtl_r <= powerCtl_nxt;
      resetN_r   <= resetN_nxt;
      offCmd_r   <= offCmd_nxt;
      done_r     <= done_nxt;
      timedOut_r <= timedOut_nxt;
    end
  end

  // Busy is the registered complement of the idle state.
  logic busy_r;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      busy_r <= 1'b0;
    end else begin
      busy_r <= (state_nxt != mprs_pkg::HST_IDLE);
    end
  end

  assign pins.powerCtl = powerCtl_r;
  assign pins.resetN   = resetN_r;
  assign pins.offCmd   = offCmd_r;
  assign busy          = busy_r;
  assign done          = done_r;
  assign timedOut      = timedOut_r;

endmodule : mprs_host

// ---- dv/mprs_chk.sv ----
// Concurrent checks on the pins that join the host end to the module end.
module mprs_chk #(
  parameter int unsigned ON_MIN    = 20,
  parameter int unsigned RST_MIN   = 10,
  parameter int unsigned HWOFF_MIN = 50,
  parameter int unsigned HWRST_PRE = 100
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Pins between the two ends.
  input wire logic powerCtl,
  input wire logic resetN,
  input wire logic offCmd,
  input wire logic offOk
);
  timeunit 1ns;
  timeprecision 1ps;

  mprs_pkg::mprs_cnt_t hiCnt_r;
  mprs_pkg::mprs_cnt_t loCnt_r;
  mprs_pkg::mprs_cnt_t rstLoCnt_r;
  logic                pend_r;

  // Counts how long each power control level and the reset low level have lasted and remembers an unanswered command.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      hiCnt_r    <= '0;
      loCnt_r    <= '0;
      rstLoCnt_r <= '0;
      pend_r     <= 1'b0;
    end else begin
      hiCnt_r    <= powerCtl ? hiCnt_r + 1 : '0;
      loCnt_r    <= powerCtl ? '0 : loCnt_r + 1;
      rstLoCnt_r <= resetN ? '0 : rstLoCnt_r + 1;
      pend_r     <= offCmd | (pend_r & ~offOk);
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  // ****************************************************************
  // Pin timing properties
  // ****************************************************************
  property p_on_hold;
    $fell(powerCtl) |-> hiCnt_r > ON_MIN;
  endproperty
  a_on_hold: assert property (p_on_hold) else $error("power control high too short");
  property p_lo_hold;
    $rose(powerCtl) |-> loCnt_r > HWOFF_MIN;
  endproperty
  a_lo_hold: assert property (p_lo_hold) else $error("power control low too short");
  property p_rst_pulse;
    $rose(resetN) |-> rstLoCnt_r > RST_MIN;
  endproperty
  a_rst_pulse: assert property (p_rst_pulse) else $error("reset pulse too short");
  property p_hw_pre;
    $fell(powerCtl) |-> resetN || (rstLoCnt_r >= HWRST_PRE - 1);
  endproperty
  a_hw_pre: assert property (p_hw_pre) else $error("forced off without reset lead");
  property p_cmd_when_on;
    offCmd |-> powerCtl && resetN;
  endproperty
  a_cmd_when_on: assert property (p_cmd_when_on) else $error("command while off");
  property p_cmd_pulse;
    offCmd |=> !offCmd;
  endproperty
  a_cmd_pulse: assert property (p_cmd_pulse) else $error("command longer than a cycle");
  property p_ok_pulse;
    offOk |=> !offOk;
  endproperty
  a_ok_pulse: assert property (p_ok_pulse) else $error("reply longer than a cycle");
  property p_ok_after_cmd;
    offOk |-> pend_r;
  endproperty
  a_ok_after_cmd: assert property (p_ok_after_cmd) else $error("reply without command");
  property p_final_steps;
    offCmd |=> !offOk [*4];
  endproperty
  a_final_steps: assert property (p_final_steps) else $error("reply before finalization");
  property p_ok_power;
    offOk |-> powerCtl;
  endproperty
  a_ok_power: assert property (p_ok_power) else $error("power dropped before reply");

  // Main scenarios reached.
  c_start: cover property ($rose(powerCtl));
  c_ok:    cover property (offOk);
  c_hwoff: cover property ($fell(powerCtl) && !resetN);
  c_reset: cover property ($rose(resetN) && powerCtl);
endmodule : mprs_chk

// ---- dv/mprs_bench.sv ----
// Self-checking bench joining the host end to the module end.
module mprs_bench;
  timeunit 1ns;
  timeprecision 1ps;

  logic       clk;
  logic       rst_n;
  logic [3:0] reqV;
  logic       stall;
  logic       saveDone;
  logic       clearDone;
  logic       bootStart;
  logic       moduleReady;
  logic       saveStart;
  logic       clearStart;
  logic       pmuPowered;
  logic       usbHighSpeed;
  logic       usbFullSpeed;
  logic       busy;
  logic       done;
  logic       timedOut;
  int         err_total;
  int         num_checks;
  int         boots = 0;
  int         oks = 0;
  int         dones = 0;

  // Shortened times so that the run stays brief.
  localparam int unsigned HOLD_CYC  = 100;
  localparam int unsigned SD_CYC    = 500;
  localparam int unsigned ONMIN_CYC = 20;
  localparam int unsigned RSTMN_CYC = 10;
  localparam int unsigned LOMIN_CYC = 50;

  mprs_if i_mprs_if ();

  // ****************************************************************
  // Both ends and the checker
  // ****************************************************************
  mprs_host #(.T_ON_HOLD_CYC(HOLD_CYC), .T_RST_HOLD_CYC(HOLD_CYC), .T_HWOFF_HOLD_CYC(HOLD_CYC),
    .T_HWRST_PRE_CYC(HOLD_CYC), .T_SD_MAX_CYC(SD_CYC)) i_mprs_host (
    .clk(clk), .rst_n(rst_n), .pins(i_mprs_if.host), .startReq(reqV[0]),
    .resetReq(reqV[1]), .swOffReq(reqV[2]), .hwOffReq(reqV[3]), .busy(busy),
    .done(done), .timedOut(timedOut));
  mprs_device #(.T_ON_MIN_CYC(ONMIN_CYC), .T_RST_MIN_CYC(RSTMN_CYC),
    .T_HWOFF_MIN_CYC(LOMIN_CYC)) i_mprs_device (
    .clk(clk), .rst_n(rst_n), .pins(i_mprs_if.dev), .saveDone(saveDone),
    .clearDone(clearDone), .bootStart(bootStart), .moduleReady(moduleReady),
    .saveStart(saveStart), .clearStart(clearStart), .pmuPowered(pmuPowered),
    .usbHighSpeed(usbHighSpeed), .usbFullSpeed(usbFullSpeed));
  mprs_chk #(.ON_MIN(ONMIN_CYC), .RST_MIN(RSTMN_CYC), .HWOFF_MIN(LOMIN_CYC),
    .HWRST_PRE(HOLD_CYC)) i_mprs_chk (
    .clk(clk), .rst_n(rst_n), .powerCtl(i_mprs_if.powerCtl), .resetN(i_mprs_if.resetN),
    .offCmd(i_mprs_if.offCmd), .offOk(i_mprs_if.offOk));

  // Makes the 4 ns clock.
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // Firmware stand-in answers each finalization step a cycle later; stall holds back only the save step.
  always @(posedge clk) begin
    saveDone  <= saveStart & ~stall;
    clearDone <= clearStart;
  end

  // Counts boot pulses, replies and sequence ends.
  always @(posedge clk) begin
    if (bootStart === 1'b1) boots++;
    if (i_mprs_if.offOk === 1'b1) oks++;
    if (done === 1'b1) dones++;
  end

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic chk_bit(input logic got, input logic exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_bit

  task automatic chk_cnt(input int got, input int exp);
    num_checks++;
    if (got != exp) begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_cnt

  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask : idle

  task automatic issue(input logic [3:0] r);
    @(posedge clk);
    reqV <= r;
    @(posedge clk);
    reqV <= 4'h0;
  endtask : issue

  task automatic wait_done(input int lim);
    int n;
    n = 0;
    while (done !== 1'b1 && n < lim) begin
      @(posedge clk);
      n++;
    end
    chk_bit(done, 1'b1);
  endtask : wait_done

  task automatic final_report();
    if (err_total == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : final_report

  // Cuts a hang short.
  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    final_report();
  end

  // ****************************************************************
  // Test sequence
  // ****************************************************************
  initial begin
    rst_n = 1'b0;
    reqV = 4'h0;
    stall = 1'b0;
    err_total = 0;
    num_checks = 0;
    idle(8);
    rst_n <= 1'b1;
    idle(60);
    chk_bit(usbHighSpeed, 1'b1);
    chk_bit(usbFullSpeed, 1'b1);
    chk_bit(pmuPowered, 1'b0);
    // Start-up with a reset request thrown in while busy.
    issue(4'h1);
    idle(10);
    chk_bit(busy, 1'b1);
    issue(4'h2);
    wait_done(200);
    idle(3);
    chk_bit(busy, 1'b0);
    chk_bit(moduleReady, 1'b1);
    chk_bit(pmuPowered, 1'b1);
    chk_cnt(boots, 1);
    idle(120);
    chk_cnt(dones, 1);
    chk_bit(i_mprs_if.resetN, 1'b1);
    // Reset keeps the power unit up and restarts on release.
    issue(4'h2);
    idle(50);
    chk_bit(moduleReady, 1'b0);
    chk_bit(pmuPowered, 1'b1);
    wait_done(200);
    idle(3);
    chk_bit(moduleReady, 1'b1);
    chk_cnt(boots, 2);
    // Software power-down answered by the module.
    issue(4'h4);
    wait_done(800);
    idle(3);
    chk_bit(pmuPowered, 1'b0);
    chk_bit(moduleReady, 1'b0);
    chk_cnt(oks, 1);
    chk_bit(timedOut, 1'b0);
    chk_bit(i_mprs_if.powerCtl, 1'b0);
    // Start again, then a power-down that never answers.
    issue(4'h1);
    wait_done(200);
    idle(3);
    chk_cnt(boots, 3);
    stall <= 1'b1;
    issue(4'h4);
    wait_done(900);
    idle(3);
    chk_bit(timedOut, 1'b1);
    chk_bit(pmuPowered, 1'b0);
    chk_cnt(oks, 1);
    stall <= 1'b0;
    // Start again, then forced off with reset leading.
    issue(4'h1);
    wait_done(200);
    idle(3);
    chk_bit(pmuPowered, 1'b1);
    issue(4'h8);
    idle(50);
    chk_bit(i_mprs_if.resetN, 1'b0);
    chk_bit(pmuPowered, 1'b1);
    wait_done(400);
    idle(3);
    chk_bit(pmuPowered, 1'b0);
    chk_bit(moduleReady, 1'b0);
    final_report();
  end
endmodule : mprs_bench
